// file: core/sffe_top.sv
// Functional notes
// - Single-line mode samples instruction, address and data on rising clock edges.
// - Link works in clock modes zero and three; host idles clock accordingly.
// - Instruction 35h enters four-line command mode for all later phases.
// - In four-line mode all four pins are data lanes 0 to 3.
// - Instruction F5h leaves four-line mode, back to single-line instructions.
// - Power-on, pin or software reset returns the device to single-line mode; pin reset is ignored in four-line mode.
// - Four-line mode moves an instruction in two clocks, four bits each.
// - Double-rate fast read takes address and drives data on both edges.
// - Erased memory reads all ones.
// - Erase granularity: 4K sector, 32K block, 64K block, whole array.
// - One program writes 1 to 256 bytes within a single page.
// - Reads may wrap in bursts of 8, 16, 32 or 64 bytes.
// - Output drive strength selects one of six settings.
// - Addresses are three or four bytes per the current address mode.
// - Single-line mode drives status and single-lane read data only on the output pin.
// - Single-line instructions may use two or four lanes for later phases.
// - Shared pin is pause by default, reset when select bit 7 is set.
`include "sffe_defs.svh"

module sffe_fifo
  import sffe_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("sffe_fifo: DEPTH must be a power of two");
  end

  // Extra pointer bit tells full from empty
  assign in_ready  = !((wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
  assign out_valid = (wp_reg != rp_reg);
  assign out_data  = mem[rp_reg[AW-1:0]];

  // Storage
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) mem[wp_reg[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (in_valid && in_ready) wp_reg <= wp_reg + 1'b1;
      if (out_valid && out_ready) rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule

module sffe_top
  import sffe_pkg::*;
#(
  parameter int MEM_BYTES    = 256,
  parameter int FIFO_DEPTH   = 16,
  parameter int ERASE_CYCLES = 64
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_i,
  output logic [3:0]       io_o,
  output logic [3:0]       io_oe,
  output logic [2:0]       drive_strength
);
  localparam int AW = $clog2(MEM_BYTES);

  if (MEM_BYTES < 16 || (MEM_BYTES & (MEM_BYTES - 1)) != 0 || ERASE_CYCLES < 2 || ERASE_CYCLES > 65535) begin : g_bad
    $error("sffe_top: unsupported MEM_BYTES or ERASE_CYCLES");
  end

  logic [5:0]  s1_reg;
  logic [5:0]  s2_reg;
  logic        sck_d_reg;
  logic        cs_d_reg;
  sffe_state_t state_reg;
  sffe_kind_t  kind_reg;
  logic [5:0]  cnt_reg;
  logic [31:0] sh_reg;
  logic [31:0] addr_reg;
  logic [2:0]  lanes_reg;
  logic [2:0]  dl_reg;
  logic        dum_reg;
  logic        dtr_reg;
  logic [5:0]  esh_reg;
  logic        quad_reg;
  logic        addr4_reg;
  logic        rsten_reg;
  logic [7:0]  op_reg;
  logic [7:0]  rp_reg;
  logic [7:0]  osh_reg;
  logic [2:0]  ocnt_reg;
  sffe_pins_t  pins_reg;
  logic        wren_reg;
  logic        ovf_reg;
  logic [15:0] er_cnt_reg;
  logic [31:0] er_addr_reg;
  logic [5:0]  er_sh_reg;
  logic [MEM_BYTES-1:0] blank_reg;
  logic [7:0]  mem [MEM_BYTES];
  logic        a_we_reg;
  logic [11:0] a_addr_reg;
  logic [31:0] hrdata_reg;

  logic        cs_s, sck_s, rise, fall, cs_rise, pin_rst, pause;
  logic        cap_ok, out_ok, op_done, wr_done, byte_end, busy, er_apply, erase_go;
  logic        soft_rst, ovf_clr, push_ready, pop, pop_valid;
  logic [3:0]  io_s;
  logic [2:0]  eff_lanes;
  logic [5:0]  ncnt, abits;
  logic [31:0] nsh, mask, next_raddr, status, rd_word;
  logic [7:0]  obyte, rd_byte, src_byte, cur_byte;
  logic [3:0]  osum;
  logic [AW-1:0] rd_idx, pop_idx;
  sffe_wr_t    push_d, pop_d;
  sffe_state_t d_state;
  sffe_kind_t  d_kind;
  logic [2:0]  d_al, d_dl;
  logic        d_dum, d_dtr;
  logic [5:0]  d_esh;

  function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [3:0] d, input logic [2:0] n);
    case (n)
      3'h4:    return {s[27:0], d};
      3'h2:    return {s[29:0], d[1:0]};
      default: return {s[30:0], d[0]};
    endcase
  endfunction

  // Pin synchronisers; the link clock is just another slow input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg    <= 6'h3F;
      s2_reg    <= 6'h3F;
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end else begin
      s1_reg    <= {cs_n, sck, io_i};
      s2_reg    <= s1_reg;
      sck_d_reg <= s2_reg[4];
      cs_d_reg  <= s2_reg[5];
    end
  end

  assign cs_s    = s2_reg[5];
  assign sck_s   = s2_reg[4];
  assign io_s    = s2_reg[3:0];
  assign cs_rise = cs_s & ~cs_d_reg;
  // Edges found regardless of idle level, so mode 0 and mode 3 both work
  assign rise = sck_s & ~sck_d_reg & ~cs_s;
  assign fall = ~sck_s & sck_d_reg & ~cs_s;

  // Shared pin role; in four-line mode it is a data lane and neither function applies
  assign pin_rst = rp_reg[`SFFE_RP_PRS] & ~quad_reg & ~io_s[3];
  assign pause   = ~rp_reg[`SFFE_RP_PRS] & ~quad_reg & (lanes_reg != 3'h4) & ~io_s[3];

  // Input sampling: rising edges, plus falling edges for a double-rate address;
  // the fall right after the opcode is no address edge, so 24 bits take 12 clocks
  assign cap_ok = (rise | (dtr_reg & fall & (state_reg == ST_ADDR) & (cnt_reg != 6'h00)))
                  & (state_reg != ST_RDATA) & ~pause;
  assign out_ok = (state_reg == ST_RDATA) & (fall | (dtr_reg & rise)) & ~pause;
  assign eff_lanes = (state_reg == ST_CMD) ? (quad_reg ? 3'h4 : 3'h1) : lanes_reg;
  assign nsh     = shift_in(sh_reg, io_s, eff_lanes);
  assign ncnt    = cnt_reg + {3'h0, eff_lanes};
  assign obyte   = nsh[7:0];
  assign abits   = addr4_reg ? `SFFE_ABITS4 : `SFFE_ABITS3;
  assign op_done = cap_ok & (state_reg == ST_CMD) & (ncnt == 6'h08);
  assign wr_done = cap_ok & (state_reg == ST_WDATA) & (ncnt == 6'h08);

  // Instruction decode
  always_comb begin
    d_state = ST_SKIP;
    d_kind  = K_NONE;
    d_al    = quad_reg ? 3'h4 : 3'h1;
    d_dl    = quad_reg ? 3'h4 : 3'h1;
    d_dum   = 1'b0;
    d_dtr   = 1'b0;
    d_esh   = `SFFE_SH_CHIP;
    case (obyte)
      `SFFE_OP_RD:   begin d_state = ST_ADDR; d_kind = K_READ; end
      `SFFE_OP_FRD:  begin d_state = ST_ADDR; d_kind = K_READ; d_dum = 1'b1; end
      `SFFE_OP_DOR:  begin d_state = ST_ADDR; d_kind = K_READ; d_dum = 1'b1; d_dl = quad_reg ? 3'h4 : 3'h2; end
      `SFFE_OP_QOR:  begin d_state = ST_ADDR; d_kind = K_READ; d_dum = 1'b1; d_dl = 3'h4; end
      `SFFE_OP_QIO:  begin d_state = ST_ADDR; d_kind = K_READ; d_dum = 1'b1; d_al = 3'h4; d_dl = 3'h4; end
      `SFFE_OP_DTR:  begin d_state = ST_ADDR; d_kind = K_READ; d_dum = 1'b1; d_dtr = 1'b1; end
      `SFFE_OP_PP:   begin d_state = ST_ADDR; d_kind = K_PROG; end
      `SFFE_OP_QPP:  begin d_state = ST_ADDR; d_kind = K_PROG; d_dl = 3'h4; end
      `SFFE_OP_SE:   begin d_state = ST_ADDR; d_kind = K_ERASE; d_esh = `SFFE_SH_4K; end
      `SFFE_OP_BE32: begin d_state = ST_ADDR; d_kind = K_ERASE; d_esh = `SFFE_SH_32K; end
      `SFFE_OP_BE64: begin d_state = ST_ADDR; d_kind = K_ERASE; d_esh = `SFFE_SH_64K; end
      `SFFE_OP_CE,
      `SFFE_OP_CE2:  d_kind = K_ERASE;
      `SFFE_OP_RDSR: begin d_state = ST_RDATA; d_kind = K_STAT; end
      `SFFE_OP_SRP:  begin d_state = ST_PARAM; d_kind = K_PARAM; end
      default:       d_kind = K_NONE;
    endcase
  end

  // Read address; wrap keeps the upper bits inside the burst window
  assign mask       = (32'h0000_0008 << rp_reg[`SFFE_RP_BL_LSB +: 2]) - 32'h0000_0001;
  assign next_raddr = rp_reg[`SFFE_RP_WRAP] ? ((addr_reg & ~mask) | ((addr_reg + 32'h1) & mask))
                                             : addr_reg + 32'h1;
  assign osum     = {1'b0, ocnt_reg} + {1'b0, lanes_reg};
  assign byte_end = osum[3];

  // Command sequencing; chip select high always returns to instruction phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_CMD;
      kind_reg  <= K_NONE;
      cnt_reg   <= 6'h00;
      sh_reg    <= 32'h0;
      addr_reg  <= 32'h0;
      lanes_reg <= 3'h1;
      dl_reg    <= 3'h1;
      dum_reg   <= 1'b0;
      dtr_reg   <= 1'b0;
      esh_reg   <= 6'h00;
    end else if (cs_s | pin_rst | soft_rst) begin
      state_reg <= ST_CMD;
      cnt_reg   <= 6'h00;
      dtr_reg   <= 1'b0;
      lanes_reg <= 3'h1;
    end else if (cap_ok) begin
      sh_reg  <= nsh;
      cnt_reg <= ncnt;
      case (state_reg)
        ST_CMD: if (ncnt == 6'h08) begin
          cnt_reg   <= 6'h00;
          state_reg <= d_state;
          kind_reg  <= d_kind;
          lanes_reg <= (d_state == ST_ADDR) ? d_al : d_dl;
          dl_reg    <= d_dl;
          dum_reg   <= d_dum;
          dtr_reg   <= d_dtr;
          esh_reg   <= d_esh;
        end
        ST_ADDR: if (ncnt == abits) begin
          cnt_reg   <= 6'h00;
          addr_reg  <= addr4_reg ? nsh : {8'h00, nsh[23:0]};
          lanes_reg <= dl_reg;
          if (kind_reg == K_ERASE) state_reg <= ST_SKIP;
          else if (dum_reg) state_reg <= ST_DUMMY;
          else if (kind_reg == K_PROG) state_reg <= ST_WDATA;
          else state_reg <= ST_RDATA;
        end
        ST_DUMMY: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == `SFFE_DUMMY - 6'h01) state_reg <= ST_RDATA;
        end
        ST_WDATA: if (ncnt == 6'h08) begin
          cnt_reg       <= 6'h00;
          addr_reg[7:0] <= addr_reg[7:0] + 8'h01;
        end
        ST_PARAM: if (ncnt == 6'h08) begin
          cnt_reg   <= 6'h00;
          state_reg <= ST_SKIP;
        end
        default: cnt_reg <= cnt_reg;
      endcase
    end else if (out_ok && byte_end && kind_reg == K_READ) begin
      addr_reg <= next_raddr;
    end
  end

  // Mode flags; any reset drops back to single-line, three-byte addressing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quad_reg  <= 1'b0;
      addr4_reg <= 1'b0;
      rsten_reg <= 1'b0;
      op_reg    <= 8'h00;
    end else if (pin_rst | soft_rst) begin
      quad_reg  <= 1'b0;
      addr4_reg <= 1'b0;
      rsten_reg <= 1'b0;
    end else if (op_done) begin
      op_reg    <= obyte;
      rsten_reg <= (obyte == `SFFE_OP_RSTEN);
      if (obyte == `SFFE_OP_QEN) quad_reg <= 1'b1;
      if (obyte == `SFFE_OP_QEX) quad_reg <= 1'b0;
      if (obyte == `SFFE_OP_A4EN) addr4_reg <= 1'b1;
      if (obyte == `SFFE_OP_A4EX) addr4_reg <= 1'b0;
      if (obyte == `SFFE_OP_RST && rsten_reg) begin
        quad_reg  <= 1'b0;
        addr4_reg <= 1'b0;
      end
    end
  end

  // Read parameters from the link or the bus; drive strength saturates at six settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rp_reg <= `SFFE_RP_RST;
    end else if (pin_rst | soft_rst) begin
      rp_reg <= `SFFE_RP_RST;
    end else if (cap_ok && state_reg == ST_PARAM && ncnt == 6'h08) begin
      rp_reg <= {obyte[7:3], (obyte[2:0] > `SFFE_RP_DS_MAX) ? `SFFE_RP_DS_MAX : obyte[2:0]};
    end else if (a_we_reg && a_addr_reg == `SFFE_OFF_RDPAR) begin
      rp_reg <= {hwdata[7:3], (hwdata[2:0] > `SFFE_RP_DS_MAX) ? `SFFE_RP_DS_MAX : hwdata[2:0]};
    end
  end
  assign drive_strength = rp_reg[`SFFE_RP_DS_LSB +: 3];

  // Output shifter; reads do not see bytes still waiting in the FIFO
  assign rd_idx   = addr_reg[AW-1:0];
  assign rd_byte  = blank_reg[rd_idx] ? 8'hFF : mem[rd_idx];
  assign src_byte = (kind_reg == K_STAT) ? {4'h0, addr4_reg, quad_reg, ovf_reg, busy} : rd_byte;
  assign cur_byte = (ocnt_reg == 3'h0) ? src_byte : osh_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osh_reg  <= 8'h00;
      ocnt_reg <= 3'h0;
      pins_reg <= '0;
    end else if (cs_s | pin_rst | soft_rst) begin
      osh_reg  <= 8'h00;
      ocnt_reg <= 3'h0;
      pins_reg <= '0;
    end else if (out_ok) begin
      osh_reg  <= cur_byte << lanes_reg;
      ocnt_reg <= osum[2:0];
      case (lanes_reg)
        3'h4: begin pins_reg.o <= cur_byte[7:4]; pins_reg.oe <= 4'hF; end
        3'h2: begin pins_reg.o <= {2'h0, cur_byte[7:6]}; pins_reg.oe <= 4'h3; end
        default: begin pins_reg.o <= {2'h0, cur_byte[7], 1'b0}; pins_reg.oe <= 4'h2; end
      endcase
    end
  end
  assign io_o  = pins_reg.o;
  assign io_oe = pins_reg.oe;

  // Program bytes queue up; a full FIFO drops the byte and flags overflow
  assign push_d = '{addr: addr_reg, data: obyte};
  sffe_fifo #(.W($bits(sffe_wr_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (wr_done),
    .in_ready  (push_ready),
    .in_data   (push_d),
    .out_valid (pop_valid),
    .out_ready (wren_reg & ~busy),
    .out_data  (pop_d)
  );
  assign pop     = pop_valid & wren_reg & ~busy;
  assign pop_idx = pop_d.addr[AW-1:0];

  // Overflow flag: a new overflow wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ovf_reg <= 1'b0;
    else if (wr_done && !push_ready) ovf_reg <= 1'b1;
    else if (ovf_clr) ovf_reg <= 1'b0;
  end

  // Erase timer; the writer stalls while it runs so the FIFO can fill
  assign erase_go = cs_rise & (kind_reg == K_ERASE) & (state_reg == ST_SKIP) & ~busy;
  assign busy     = (er_cnt_reg != 16'h0);
  assign er_apply = (er_cnt_reg == 16'h1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      er_cnt_reg  <= 16'h0;
      er_addr_reg <= 32'h0;
      er_sh_reg   <= 6'h00;
    end else if (erase_go) begin
      er_cnt_reg  <= 16'(ERASE_CYCLES);
      er_addr_reg <= addr_reg;
      er_sh_reg   <= esh_reg;
    end else if (busy) begin
      er_cnt_reg <= er_cnt_reg - 16'h1;
    end
  end

  // Blank map; a shift of 32 clears every address compare, giving chip erase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blank_reg <= '1;
    end else begin
      if (pop) blank_reg[pop_idx] <= 1'b0;
      if (er_apply) begin
        for (int i = 0; i < MEM_BYTES; i++) begin
          if (((32'(i) ^ er_addr_reg) >> er_sh_reg) == 32'h0) blank_reg[i] <= 1'b1;
        end
      end
    end
  end

  // Array write; programming only clears bits
  always_ff @(posedge hclk) begin
    if (pop) mem[pop_idx] <= blank_reg[pop_idx] ? pop_d.data : (mem[pop_idx] & pop_d.data);
  end

  // AHB-Lite slave, zero wait states
  always_comb begin
    status = 32'h0;
    status[`SFFE_ST_QUAD]  = quad_reg;
    status[`SFFE_ST_ADDR4] = addr4_reg;
    status[`SFFE_ST_BUSY]  = busy;
    status[`SFFE_ST_OVF]   = ovf_reg;
    status[`SFFE_ST_EMPTY] = ~pop_valid;
    status[`SFFE_ST_STATE +: 3] = state_reg;
    if (haddr[11:0] == `SFFE_OFF_CTRL) rd_word = {30'h0, wren_reg, 1'b0};
    else if (haddr[11:0] == `SFFE_OFF_STATUS) rd_word = status;
    else if (haddr[11:0] == `SFFE_OFF_RDPAR) rd_word = {24'h0, rp_reg};
    else if (haddr[11:0] == `SFFE_OFF_LASTOP) rd_word = {24'h0, op_reg};
    else rd_word = 32'h0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_we_reg   <= 1'b0;
      a_addr_reg <= 12'h000;
      hrdata_reg <= 32'h0;
    end else begin
      a_we_reg   <= hsel & hready & htrans[1] & hwrite;
      a_addr_reg <= haddr[11:0];
      hrdata_reg <= (hsel & hready & htrans[1] & ~hwrite) ? rd_word : 32'h0;
    end
  end
  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign soft_rst  = a_we_reg & (a_addr_reg == `SFFE_OFF_CTRL) & hwdata[`SFFE_CTRL_SRST];
  assign ovf_clr   = a_we_reg & (a_addr_reg == `SFFE_OFF_CTRL) & hwdata[`SFFE_CTRL_OVFCLR];

  // Writer enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wren_reg <= `SFFE_WREN_RST;
    else if (a_we_reg && a_addr_reg == `SFFE_OFF_CTRL) wren_reg <= hwdata[`SFFE_CTRL_WREN];
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_single_so;
    (!quad_reg && lanes_reg == 3'h1) |-> (pins_reg.oe == 4'h0 || pins_reg.oe == 4'h2);
  endproperty
  a_single_so: assert property (p_single_so) else $error("extra pin driven in single mode");
  property p_cs_quiet;
    cs_s |=> (pins_reg.oe == 4'h0 && state_reg == ST_CMD);
  endproperty
  a_cs_quiet: assert property (p_cs_quiet) else $error("activity while deselected");
  property p_enter;
    (op_done && obyte == `SFFE_OP_QEN && !soft_rst && !pin_rst) |=> quad_reg;
  endproperty
  a_enter: assert property (p_enter) else $error("four-line mode not entered");
  property p_exit;
    (op_done && obyte == `SFFE_OP_QEX) |=> !quad_reg;
  endproperty
  a_exit: assert property (p_exit) else $error("four-line mode not left");
  property p_reset_mode;
    (pin_rst || soft_rst) |=> (!quad_reg && !addr4_reg && state_reg == ST_CMD);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset kept mode");
  property p_nibble;
    (cap_ok && state_reg == ST_CMD && quad_reg && cnt_reg == 6'h00 && !soft_rst) |=> cnt_reg == 6'h04;
  endproperty
  a_nibble: assert property (p_nibble) else $error("instruction nibble miscounted");
  property p_ds;
    drive_strength <= `SFFE_RP_DS_MAX;
  endproperty
  a_ds: assert property (p_ds) else $error("drive strength out of range");
  property p_erase_stall;
    erase_go |=> (busy && !pop) [*2];
  endproperty
  a_erase_stall: assert property (p_erase_stall) else $error("writer ran during erase");
  property p_blank;
    er_apply |=> blank_reg[er_addr_reg[AW-1:0]];
  endproperty
  a_blank: assert property (p_blank) else $error("erased byte not all ones");
  property p_page;
    (wr_done && !soft_rst && !pin_rst) |=> addr_reg[31:8] == $past(addr_reg[31:8]);
  endproperty
  a_page: assert property (p_page) else $error("program left its page");
endmodule

// file: common/sffe_defs.svh
`ifndef SFFE_DEFS_SVH
`define SFFE_DEFS_SVH
// Register byte offsets
`define SFFE_OFF_CTRL   12'h000
`define SFFE_OFF_STATUS 12'h004
`define SFFE_OFF_RDPAR  12'h008
`define SFFE_OFF_LASTOP 12'h00C
// Control bits
`define SFFE_CTRL_SRST   0
`define SFFE_CTRL_WREN   1
`define SFFE_CTRL_OVFCLR 2
`define SFFE_WREN_RST    1'b1
// Status bits
`define SFFE_ST_QUAD  0
`define SFFE_ST_ADDR4 1
`define SFFE_ST_BUSY  2
`define SFFE_ST_OVF   3
`define SFFE_ST_EMPTY 4
`define SFFE_ST_STATE 5
// Read parameter fields
`define SFFE_RP_DS_LSB 0
`define SFFE_RP_DS_MAX 3'h5
`define SFFE_RP_BL_LSB 3
`define SFFE_RP_WRAP   5
`define SFFE_RP_PRS    7
`define SFFE_RP_RST    8'h00
// Instruction codes
`define SFFE_OP_QEN   8'h35
`define SFFE_OP_QEX   8'hF5
`define SFFE_OP_RSTEN 8'h66
`define SFFE_OP_RST   8'h99
`define SFFE_OP_A4EN  8'hB7
`define SFFE_OP_A4EX  8'h29
`define SFFE_OP_RD    8'h03
`define SFFE_OP_FRD   8'h0B
`define SFFE_OP_DOR   8'h3B
`define SFFE_OP_QOR   8'h6B
`define SFFE_OP_QIO   8'hEB
`define SFFE_OP_DTR   8'h0D
`define SFFE_OP_PP    8'h02
`define SFFE_OP_QPP   8'h32
`define SFFE_OP_SE    8'h20
`define SFFE_OP_BE32  8'h52
`define SFFE_OP_BE64  8'hD8
`define SFFE_OP_CE    8'hC7
`define SFFE_OP_CE2   8'h60
`define SFFE_OP_RDSR  8'h05
`define SFFE_OP_SRP   8'hC0
// Counts and shifts
`define SFFE_DUMMY   6'h08
`define SFFE_ABITS3  6'h18
`define SFFE_ABITS4  6'h20
`define SFFE_SH_4K   6'h0C
`define SFFE_SH_32K  6'h0F
`define SFFE_SH_64K  6'h10
`define SFFE_SH_CHIP 6'h20
`endif

// file: common/sffe_pkg.sv
package sffe_pkg;
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_PARAM, ST_SKIP} sffe_state_t;
  typedef enum logic [2:0] {K_NONE, K_READ, K_STAT, K_PROG, K_ERASE, K_PARAM} sffe_kind_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  data;
  } sffe_wr_t;
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } sffe_pins_t;
endpackage

// file: tb/sffe_host.sv
// Host side of the link: mode 0, clock low between frames
module sffe_host (
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      io,
  input  wire logic [3:0] din
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 40;
  // Idle clock low, lines pulled high
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io = 4'hF;
  end
  task automatic open_frame();
    cs_n <= 1'b0;
    #HALF;
  endtask
  // MSB first, one lane or a nibble per clock
  task automatic put(input logic [7:0] b, input bit quad);
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      if (quad) io <= i ? b[3:0] : b[7:4];
      else io <= {3'h7, b[7-i]};
      #HALF sck <= 1'b1;
      #HALF sck <= 1'b0;
    end
  endtask
  // Address on both edges; bit changes half way between edges
  task automatic put_dtr(input logic [7:0] b);
    for (int i = 0; i < 8; i += 2) begin
      io <= {3'h7, b[7-i]};
      #(HALF/2) sck <= 1'b1;
      #(HALF/2) io <= {3'h7, b[6-i]};
      #(HALF/2) sck <= 1'b0;
      #(HALF/2);
    end
  endtask
  // Sample on rising edges over one, two or four lanes; pause lane kept high
  task automatic get(output logic [7:0] b, input int n);
    b = 8'h00;
    io <= (n == 1) ? {3'h7, ~io[0]} : 4'hF;
    for (int i = 0; i < 8 / n; i++) begin
      #HALF sck <= 1'b1;
      if (n == 4) b = {b[3:0], din};
      else if (n == 2) b = {b[5:0], din[1:0]};
      else b = {b[6:0], din[1]};
      #HALF sck <= 1'b0;
    end
  endtask
  // Double-rate read: one bit at each edge, before the device moves on
  task automatic get_dtr(output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 4; i++) begin
      #HALF sck <= 1'b1;
      b = {b[6:0], din[1]};
      #HALF sck <= 1'b0;
      b = {b[6:0], din[1]};
    end
  endtask
  // Hold the lines for one link period while deselected
  task automatic lines(input logic [3:0] v);
    io <= v;
    #(2 * HALF);
  endtask
  // Deselect, then leave room for erase or page writes to finish
  task automatic close_frame();
    #HALF cs_n <= 1'b1;
    io <= 4'hF;
    #200;
  endtask
endmodule

// file: tb/sffe_top_tb.sv
module sffe_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp, sck, cs_n;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize, drive_strength;
  logic [3:0]  h_io, io_i, io_o, io_oe;
  logic [7:0]  b;
  int          miscompares = 0;
  int          n_checks = 0;
  always #2.5 hclk = ~hclk;
  sffe_top #(.ERASE_CYCLES(4)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sck(sck), .cs_n(cs_n), .io_i(io_i),
    .io_o(io_o), .io_oe(io_oe), .drive_strength(drive_strength));
  sffe_host host (.sck(sck), .cs_n(cs_n), .io(h_io), .din(io_i));
  // Wire level: device wins where it enables its driver
  assign io_i = (io_oe & io_o) | (~io_oe & h_io);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; waits on hready, data taken at the second edge
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] op, input bit quad);
    host.open_frame();
    host.put(op, quad);
    host.close_frame();
  endtask
  // Opcode and 3-byte address; the frame stays open
  task automatic head(input logic [7:0] op, input logic [7:0] a);
    host.open_frame();
    host.put(op, 1'b0);
    host.put(8'h00, 1'b0);
    host.put(8'h00, 1'b0);
    host.put(a, 1'b0);
  endtask
  // Then one data byte in or out for 03h or 02h; none for other opcodes
  task automatic mem(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
    head(op, a);
    if (op == 8'h03) host.get(b, 1);
    else if (op == 8'h02) host.put(d, 1'b0);
    host.close_frame();
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Whole run is some tens of microseconds
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h10);
    ahb(1'b1, 12'h008, 32'h7);
    ahb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h5);
    chk({29'h0, drive_strength}, 32'h5);
    ahb(1'b0, 12'h010, 32'h0);
    chk(q, 32'h0);
    cmd(8'h35, 1'b0);
    ahb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h11);
    cmd(8'hF5, 1'b1);
    ahb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h10);
    cmd(8'h35, 1'b0);
    ahb(1'b1, 12'h000, 32'h3);
    ahb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h10);
    cmd(8'h35, 1'b0);
    cmd(8'h66, 1'b1);
    cmd(8'h99, 1'b1);
    ahb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h10);
    cmd(8'hB7, 1'b0);
    host.open_frame();
    host.put(8'h05, 1'b0);
    host.get(b, 1);
    chk({24'h0, b}, 32'h08);
    chk({28'h0, io_oe}, 32'h2);
    host.close_frame();
    cmd(8'h29, 1'b0);
    mem(8'h03, 8'h10, 8'h00);
    chk({24'h0, b}, 32'hFF);
    mem(8'h02, 8'h20, 8'hA5);
    mem(8'h03, 8'h20, 8'h00);
    chk({24'h0, b}, 32'hA5);
    head(8'h6B, 8'h20);
    host.put(8'h00, 1'b0);
    host.get(b, 4);
    chk({20'h0, io_oe, b}, 32'hFA5);
    host.close_frame();
    host.open_frame();
    host.put(8'h0D, 1'b0);
    host.put_dtr(8'h00);
    host.put_dtr(8'h00);
    host.put_dtr(8'h20);
    host.put(8'h00, 1'b0);
    host.get_dtr(b);
    chk({24'h0, b}, 32'hA5);
    host.close_frame();
    ahb(1'b1, 12'h008, 32'h20);
    head(8'h03, 8'h27);
    host.get(b, 1);
    chk({24'h0, b}, 32'hFF);
    host.get(b, 1);
    chk({24'h0, b}, 32'hA5);
    host.close_frame();
    mem(8'h20, 8'h20, 8'h00);
    mem(8'h03, 8'h20, 8'h00);
    chk({24'h0, b}, 32'hFF);
    ahb(1'b1, 12'h008, 32'h80);
    cmd(8'hB7, 1'b0);
    host.lines(4'h7);
    host.lines(4'hF);
    ahb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h10);
    ahb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0);
    stop_test();
  end
endmodule
